// [include/msi_stat_map.svh]
// constants for the statistics increment pulse generator
`ifndef MSI_STAT_MAP_SVH
`define MSI_STAT_MAP_SVH

// ----------------------------------------
// widths and channel indices
// ----------------------------------------
`define MSI_LEN_W    16
`define MSI_NUM_CH   2
`define MSI_CH_TX    0
`define MSI_CH_RX    1

// ----------------------------------------
// frame length bin limits, in bytes
// ----------------------------------------
`define MSI_MIN_FRAME  16'h0040
`define MSI_TOP_127    16'h007F
`define MSI_TOP_255    16'h00FF
`define MSI_TOP_511    16'h01FF
`define MSI_TOP_1023   16'h03FF
`define MSI_TOP_1518   16'h05EE

// ----------------------------------------
// timing: cycles from frame report to pulse
// ----------------------------------------
`define MSI_PULSE_LAT  1

`endif

// [include/msi_pkg.sv]
// types for the statistics increment pulse generator
`include "msi_stat_map.svh"

package msi_pkg;

  // ----------------------------------------
  // destination class, one-hot
  // ----------------------------------------
  typedef enum logic [2:0] {
    MSI_UCAST = 3'h1,
    MSI_MCAST = 3'h2,
    MSI_BCAST = 3'h4
  } msi_dest_e;

  typedef logic [`MSI_LEN_W-1:0] msi_len_t;

  // ----------------------------------------
  // frame summary, reported once at frame end
  // ----------------------------------------
  typedef struct packed {
    logic      valid;
    msi_len_t  len;
    logic      fcs_err;
    logic      ctrl;
    logic      pause;
    msi_dest_e dest;
  } msi_frame_s;

  // class vectors: bit 0 unicast, 1 multicast, 2 broadcast
  typedef struct packed {
    logic       runt;
    logic [5:0] bin;
    logic       max;
    logic       over;
    logic       fcs_err;
    logic       fragment;
    logic       jabber;
    logic       sizeok_fcserr;
    logic [2:0] data_err;
    logic [2:0] data_ok;
    logic [2:0] ctrl_ok;
    logic       pause;
    logic       pause_err;
    logic [2:0] ctrl_err;
  } msi_rx_inc_s;

  typedef struct packed {
    logic [5:0] bin;
    logic       max;
    logic       over;
    logic       fcs_err;
    logic       fragment;
    logic       jabber;
    logic       sizeok_fcserr;
    logic [2:0] data_err;
    logic [2:0] data_ok;
    logic [2:0] ctrl_ok;
    logic       pause;
  } msi_tx_inc_s;

endpackage : msi_pkg

// [src/msi_stat_pulses.sv]
// statistics increment pulse generator for the tx and rx mac paths
`timescale 1ns/10ps

`include "msi_stat_map.svh"

module msi_stat_pulses (
  // clock and reset
  input  wire logic                SYS_CLK,
  input  wire logic                NRST,
  // frame summaries from the mac datapaths
  input  wire msi_pkg::msi_frame_s TX_FRAME,
  input  wire msi_pkg::msi_frame_s RX_FRAME,
  // programmed maximum frame lengths
  input  wire msi_pkg::msi_len_t   TX_MAX_SIZE,
  input  wire msi_pkg::msi_len_t   RX_MAX_SIZE,
  // increment pulses
  output msi_pkg::msi_tx_inc_s     TX_STATS,
  output msi_pkg::msi_rx_inc_s     RX_STATS
);
  import msi_pkg::*;

  // ----------------------------------------
  // channel inputs
  // ----------------------------------------
  msi_frame_s  frm_in [`MSI_NUM_CH];
  msi_len_t    max_in [`MSI_NUM_CH];
  msi_rx_inc_s inc    [`MSI_NUM_CH];

  assign frm_in[`MSI_CH_TX] = TX_FRAME;
  assign frm_in[`MSI_CH_RX] = RX_FRAME;
  assign max_in[`MSI_CH_TX] = TX_MAX_SIZE;
  assign max_in[`MSI_CH_RX] = RX_MAX_SIZE;

  // ----------------------------------------
  // classifier, one per direction
  // ----------------------------------------
  // both directions use the same classifier code; the tx port drops the
  // runt, errored-pause and errored-control fields it does not export
  for (genvar g = 0; g < `MSI_NUM_CH; g++) begin : ch
    msi_rx_inc_s inc_d;
    msi_rx_inc_s inc_q;
    msi_len_t    len;
    logic        short_f;
    logic        over_f;
    logic        err_f;
    logic        dest_ok;
    logic [2:0]  dvec;

    always_comb begin
      len     = frm_in[g].len;
      short_f = len < `MSI_MIN_FRAME;
      over_f  = len > max_in[g];
      // a frame counts as errored on fcs or size error
      err_f   = frm_in[g].fcs_err | short_f | over_f;
      dest_ok = frm_in[g].dest inside {MSI_UCAST, MSI_MCAST, MSI_BCAST};
      // an illegal class code pulses no class output at all
      dvec    = dest_ok ? frm_in[g].dest : 3'h0;
      inc_d   = '0;
      if (frm_in[g].valid) begin
        inc_d.runt          = short_f;
        inc_d.bin[0]        = len == `MSI_MIN_FRAME;
        inc_d.bin[1]        = len > `MSI_MIN_FRAME
                              && len <= `MSI_TOP_127;
        inc_d.bin[2]        = len > `MSI_TOP_127
                              && len <= `MSI_TOP_255;
        inc_d.bin[3]        = len > `MSI_TOP_255
                              && len <= `MSI_TOP_511;
        inc_d.bin[4]        = len > `MSI_TOP_511
                              && len <= `MSI_TOP_1023;
        inc_d.bin[5]        = len > `MSI_TOP_1023
                              && len <= `MSI_TOP_1518;
        inc_d.max           = len == max_in[g];
        inc_d.over          = over_f;
        inc_d.fcs_err       = frm_in[g].fcs_err;
        inc_d.fragment      = short_f & frm_in[g].fcs_err;
        inc_d.jabber        = over_f & frm_in[g].fcs_err;
        inc_d.sizeok_fcserr = frm_in[g].fcs_err
                              & ~short_f & ~over_f;
        if (!frm_in[g].ctrl) begin
          inc_d.data_err = err_f ? dvec : 3'h0;
          inc_d.data_ok  = err_f ? 3'h0 : dvec;
        end else begin
          inc_d.ctrl_ok  = err_f ? 3'h0 : dvec;
          inc_d.ctrl_err = err_f ? dvec : 3'h0;
        end
        inc_d.pause         = frm_in[g].pause & ~err_f;
        inc_d.pause_err     = frm_in[g].pause & err_f;
      end
    end

    // registered so each pulse is a clean single flop output
    always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
        inc_q <= '0;
      end else begin
        inc_q <= inc_d;
      end
    end

    assign inc[g] = inc_q;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RX_STATS = inc[`MSI_CH_RX];

  always_comb begin
    TX_STATS               = '0;
    TX_STATS.bin           = inc[`MSI_CH_TX].bin;
    TX_STATS.max           = inc[`MSI_CH_TX].max;
    TX_STATS.over          = inc[`MSI_CH_TX].over;
    TX_STATS.fcs_err       = inc[`MSI_CH_TX].fcs_err;
    TX_STATS.fragment      = inc[`MSI_CH_TX].fragment;
    TX_STATS.jabber        = inc[`MSI_CH_TX].jabber;
    TX_STATS.sizeok_fcserr = inc[`MSI_CH_TX].sizeok_fcserr;
    TX_STATS.data_err      = inc[`MSI_CH_TX].data_err;
    TX_STATS.data_ok       = inc[`MSI_CH_TX].data_ok;
    TX_STATS.ctrl_ok       = inc[`MSI_CH_TX].ctrl_ok;
    TX_STATS.pause         = inc[`MSI_CH_TX].pause;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  msi_frame_s rxf;
  msi_frame_s txf;
  logic       rx_bad;
  logic       tx_bad;

  assign rxf    = RX_FRAME;
  assign txf    = TX_FRAME;
  assign rx_bad = rxf.fcs_err | (rxf.len < `MSI_MIN_FRAME)
                  | (rxf.len > RX_MAX_SIZE);
  assign tx_bad = txf.fcs_err | (txf.len < `MSI_MIN_FRAME)
                  | (txf.len > TX_MAX_SIZE);

  rx_runt_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid |=> RX_STATS.runt == $past(rxf.len < `MSI_MIN_FRAME))
    else $error("rx runt pulse wrong");

  rx_bin64_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.len == `MSI_MIN_FRAME |=> RX_STATS.bin == 6'h01)
    else $error("rx 64 byte bin wrong");

  rx_bin127_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.len == `MSI_TOP_127 |=> RX_STATS.bin == 6'h02)
    else $error("rx 127 byte bin wrong");

  rx_bin255_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.len == `MSI_TOP_255 |=> RX_STATS.bin == 6'h04)
    else $error("rx 255 byte bin wrong");

  rx_bin511_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.len == `MSI_TOP_511 |=> RX_STATS.bin == 6'h08)
    else $error("rx 511 byte bin wrong");

  rx_bin1023_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.len == `MSI_TOP_1023 |=> RX_STATS.bin == 6'h10)
    else $error("rx 1023 byte bin wrong");

  rx_bin1518_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.len == `MSI_TOP_1518 |=> RX_STATS.bin == 6'h20)
    else $error("rx 1518 byte bin wrong");

  rx_big_nobin_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.len > `MSI_TOP_1518 |=> RX_STATS.bin == 6'h00)
    else $error("rx bin above 1518");

  rx_max_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid |=> RX_STATS.max == $past(rxf.len == RX_MAX_SIZE))
    else $error("rx max pulse wrong");

  rx_over_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid |=> RX_STATS.over == $past(rxf.len > RX_MAX_SIZE))
    else $error("rx oversize pulse wrong");

  rx_data_err_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && !rxf.ctrl && rx_bad && rxf.dest == MSI_MCAST
    |=> RX_STATS.data_err == 3'h2 && RX_STATS.data_ok == 3'h0)
    else $error("rx errored data class wrong");

  rx_data_ok_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && !rxf.ctrl && !rx_bad && rxf.dest == MSI_BCAST
    |=> RX_STATS.data_ok == 3'h4 && RX_STATS.ctrl_ok == 3'h0)
    else $error("rx good data class wrong");

  rx_ctrl_ok_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.ctrl && !rx_bad && rxf.dest == MSI_UCAST
    |=> RX_STATS.ctrl_ok == 3'h1 && RX_STATS.data_ok == 3'h0)
    else $error("rx control class wrong");

  rx_pause_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid |=> RX_STATS.pause == $past(rxf.pause && !rx_bad))
    else $error("rx pause pulse wrong");

  rx_fcs_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid |=> RX_STATS.fcs_err == $past(rxf.fcs_err))
    else $error("rx fcs pulse wrong");

  rx_fragment_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.fcs_err && rxf.len < `MSI_MIN_FRAME
    |=> RX_STATS.fragment && RX_STATS.runt && !RX_STATS.sizeok_fcserr)
    else $error("rx fragment pulse wrong");

  rx_jabber_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.fcs_err && rxf.len > RX_MAX_SIZE
    |=> RX_STATS.jabber && RX_STATS.over)
    else $error("rx jabber pulse wrong");

  rx_sizeok_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.fcs_err && rxf.len == `MSI_MIN_FRAME
    && RX_MAX_SIZE >= `MSI_MIN_FRAME |=> RX_STATS.sizeok_fcserr)
    else $error("rx size ok fcs pulse missing");

  rx_pause_err_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid |=> RX_STATS.pause_err == $past(rxf.pause && rx_bad))
    else $error("rx errored pause wrong");

  rx_ctrl_err_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rxf.valid && rxf.ctrl && rx_bad && rxf.dest == MSI_BCAST
    |=> RX_STATS.ctrl_err == 3'h4 && RX_STATS.ctrl_ok == 3'h0)
    else $error("rx errored control wrong");

  tx_data_err_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid && !txf.ctrl && tx_bad && txf.dest == MSI_UCAST
    |=> TX_STATS.data_err == 3'h1)
    else $error("tx errored data class wrong");

  tx_data_ok_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid && !txf.ctrl && !tx_bad && txf.dest == MSI_MCAST
    |=> TX_STATS.data_ok == 3'h2 && TX_STATS.data_err == 3'h0)
    else $error("tx good data class wrong");

  tx_ctrl_ok_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid && txf.ctrl && !tx_bad && txf.dest == MSI_BCAST
    |=> TX_STATS.ctrl_ok == 3'h4)
    else $error("tx control class wrong");

  tx_pause_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid |=> TX_STATS.pause == $past(txf.pause && !tx_bad))
    else $error("tx pause pulse wrong");

  tx_fcs_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid |=> TX_STATS.fcs_err == $past(txf.fcs_err)
    && TX_STATS.sizeok_fcserr == $past(txf.fcs_err && !tx_bad
    || txf.fcs_err && txf.len >= `MSI_MIN_FRAME
    && txf.len <= TX_MAX_SIZE))
    else $error("tx fcs pulses wrong");

  tx_fragment_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid |=> TX_STATS.fragment
    == $past(txf.fcs_err && txf.len < `MSI_MIN_FRAME))
    else $error("tx fragment pulse wrong");

  tx_jabber_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid |=> TX_STATS.jabber
    == $past(txf.fcs_err && txf.len > TX_MAX_SIZE))
    else $error("tx jabber pulse wrong");

  tx_bins_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid && txf.len == `MSI_TOP_511 |=> TX_STATS.bin == 6'h08)
    else $error("tx 511 byte bin wrong");

  tx_bin64_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid && txf.len == `MSI_MIN_FRAME |=> TX_STATS.bin == 6'h01)
    else $error("tx 64 byte bin wrong");

  tx_max_over_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    txf.valid |=> TX_STATS.max == $past(txf.len == TX_MAX_SIZE)
    && TX_STATS.over == $past(txf.len > TX_MAX_SIZE))
    else $error("tx max or oversize wrong");

  rx_idle_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !rxf.valid |=> RX_STATS == '0)
    else $error("rx pulse without a frame");

  tx_idle_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !txf.valid |=> TX_STATS == '0)
    else $error("tx pulse without a frame");

  rx_one_bin_a: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $countones(RX_STATS.bin) <= 1)
    else $error("rx several bins at once");

endmodule : msi_stat_pulses

// [tb/msi_stat_counters.sv]
// statistics counter model fed by the increment pulses
`timescale 1ns/10ps

module msi_stat_counters (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // increment pulses from the block
  input  wire msi_pkg::msi_tx_inc_s tx_stats,
  input  wire msi_pkg::msi_rx_inc_s rx_stats,
  // frame totals
  output logic [31:0]               tx_frames_q,
  output logic [31:0]               rx_frames_q
);
  import msi_pkg::*;

  // ----------------------------------------
  // frame totals
  // ----------------------------------------
  // at most one size bin fires per frame, so bins give a frame total;
  // frames below 64 or above 1518 bytes are not counted here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_frames_q <= 32'h0000_0000;
      rx_frames_q <= 32'h0000_0000;
    end else begin
      if (|tx_stats.bin) tx_frames_q <= tx_frames_q + 32'h0000_0001;
      if (|rx_stats.bin) rx_frames_q <= rx_frames_q + 32'h0000_0001;
    end
  end

endmodule : msi_stat_counters

// [tb/mac_statistics_increment_pulses_bench.sv]
// self-checking bench for the statistics increment pulse generator
`timescale 1ns/10ps

module mac_statistics_increment_pulses_bench;
  import msi_pkg::*;

  typedef struct packed {
    msi_tx_inc_s t;
    msi_rx_inc_s r;
  } msi_exp_s;

  logic        sys_clk;
  logic        nrst;
  msi_frame_s  tx_frame;
  msi_frame_s  rx_frame;
  msi_len_t    tx_max;
  msi_len_t    rx_max;
  msi_tx_inc_s tx_stats;
  msi_rx_inc_s rx_stats;
  logic [31:0] tx_frames;
  logic [31:0] rx_frames;
  logic [31:0] exp_tx_n;
  logic [31:0] exp_rx_n;
  msi_exp_s    exp_q[$];
  msi_exp_s    got;
  int          fails;
  int          tests_run;
  msi_len_t    m1;
  msi_len_t    m2;
  msi_dest_e   dests[3] = '{MSI_UCAST, MSI_MCAST, MSI_BCAST};
  msi_len_t    lens[14] = '{16'h0000, 16'h003F, 16'h0040, 16'h0041,
                            16'h007F, 16'h0080, 16'h00FF, 16'h0100,
                            16'h01FF, 16'h0200, 16'h03FF, 16'h0400,
                            16'h05EE, 16'h05EF};

  // ----------------------------------------
  // block and counter model
  // ----------------------------------------
  msi_stat_pulses DUT (
    .SYS_CLK     (sys_clk),
    .NRST        (nrst),
    .TX_FRAME    (tx_frame),
    .RX_FRAME    (rx_frame),
    .TX_MAX_SIZE (tx_max),
    .RX_MAX_SIZE (rx_max),
    .TX_STATS    (tx_stats),
    .RX_STATS    (rx_stats)
  );

  msi_stat_counters counters (
    .clk         (sys_clk),
    .rst_n       (nrst),
    .tx_stats    (tx_stats),
    .rx_stats    (rx_stats),
    .tx_frames_q (tx_frames),
    .rx_frames_q (rx_frames)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // expected pulses
  // ----------------------------------------
  function automatic msi_rx_inc_s exp_rx(msi_frame_s f, msi_len_t mx);
    msi_rx_inc_s e;
    logic        sh;
    logic        ov;
    logic        er;
    logic [2:0]  dv;
    e  = '0;
    sh = f.len < 16'h0040;
    // a class code outside the one-hot set pulses no class output
    dv = (f.dest inside {MSI_UCAST, MSI_MCAST, MSI_BCAST}) ? f.dest : 3'h0;
    ov = f.len > mx;
    er = f.fcs_err | sh | ov;
    if (f.valid) begin
      e.runt          = sh;
      e.bin[0]        = f.len == 16'h0040;
      e.bin[1]        = f.len > 16'h0040 && f.len <= 16'h007F;
      e.bin[2]        = f.len > 16'h007F && f.len <= 16'h00FF;
      e.bin[3]        = f.len > 16'h00FF && f.len <= 16'h01FF;
      e.bin[4]        = f.len > 16'h01FF && f.len <= 16'h03FF;
      e.bin[5]        = f.len > 16'h03FF && f.len <= 16'h05EE;
      e.max           = f.len == mx;
      e.over          = ov;
      e.fcs_err       = f.fcs_err;
      e.fragment      = sh & f.fcs_err;
      e.jabber        = ov & f.fcs_err;
      e.sizeok_fcserr = f.fcs_err & !sh & !ov;
      if (!f.ctrl) begin
        e.data_err = er ? dv : 3'h0;
        e.data_ok  = er ? 3'h0 : dv;
      end else begin
        e.ctrl_err = er ? dv : 3'h0;
        e.ctrl_ok  = er ? 3'h0 : dv;
      end
      e.pause     = f.pause & !er;
      e.pause_err = f.pause & er;
    end
    return e;
  endfunction : exp_rx

  // transmit classes follow the same reading, without runt, errored pause and errored control
  function automatic msi_tx_inc_s exp_tx(msi_frame_s f, msi_len_t mx);
    msi_rx_inc_s r;
    r = exp_rx(f, mx);
    return {r.bin, r.max, r.over, r.fcs_err, r.fragment, r.jabber,
            r.sizeok_fcserr, r.data_err, r.data_ok, r.ctrl_ok, r.pause};
  endfunction : exp_tx

  function automatic msi_frame_s mk(logic v, msi_len_t l, logic e, logic c,
                                    logic p, msi_dest_e d);
    return '{valid: v, len: l, fcs_err: e, ctrl: c, pause: p, dest: d};
  endfunction : mk

  // a limit hit on purpose a quarter of the time, else any length
  function automatic msi_frame_s rnd(msi_len_t mx);
    msi_len_t l;
    l = ($urandom_range(3) == 0) ? mx : 16'($urandom_range(1700));
    return mk($urandom_range(3) != 0, l, 1'($urandom), 1'($urandom),
              1'($urandom), dests[$urandom_range(2)]);
  endfunction : rnd

  // ----------------------------------------
  // driver: one report per cycle, expectation noted in the same step
  // ----------------------------------------
  task automatic send(msi_frame_s tf, msi_frame_s rf, msi_len_t tm,
                      msi_len_t rm);
    msi_exp_s e;
    @(posedge sys_clk);
    tx_frame <= tf;
    rx_frame <= rf;
    tx_max   <= tm;
    rx_max   <= rm;
    e.t = exp_tx(tf, tm);
    e.r = exp_rx(rf, rm);
    exp_q.push_back(e);
    if (|e.t.bin) exp_tx_n++;
    if (|e.r.bin) exp_rx_n++;
  endtask : send

  task automatic send2(msi_frame_s f, msi_len_t m);
    send(f, f, m, m);
  endtask : send2

  task automatic results();
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // ----------------------------------------
  // monitor: pulses of a report show one cycle after the report
  // ----------------------------------------
  // the newest note belongs to a report not yet taken, so it waits
  always @(negedge sys_clk) begin
    if (exp_q.size() > 1) begin
      got = exp_q.pop_front();
      tests_run += 2;
      if (tx_stats !== got.t) begin
        fails++;
        $display("wrong value tx_stats expected %h seen %h", got.t, tx_stats);
      end
      if (rx_stats !== got.r) begin
        fails++;
        $display("wrong value rx_stats expected %h seen %h", got.r, rx_stats);
      end
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    nrst      = 1'b0;
    tx_frame  = '0;
    rx_frame  = '0;
    tx_max    = 16'h05EE;
    rx_max    = 16'h05EE;
    fails     = 0;
    tests_run = 0;
    exp_tx_n  = 32'h0000_0000;
    exp_rx_n  = 32'h0000_0000;
    void'($urandom(66974));
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    // every bin edge, clean and then with an fcs error
    for (int e = 0; e < 2; e++)
      foreach (lens[i])
        send2(mk(1'b1, lens[i], e[0], 1'b0, 1'b0, MSI_MCAST),
              16'h05EE);
    // each class with error, control and pause bits, back to back
    for (int k = 0; k < 24; k++)
      send2(mk(1'b1, 16'h0200, k[0], k[1], k[2], dests[k / 8]),
            16'h05EE);
    // class codes outside the one-hot set: size and fcs pulses only, no class pulses
    send2(mk(1'b1, 16'h0100, 1'b0, 1'b1, 1'b0, msi_dest_e'(3'h3)),
          16'h05EE);
    send2(mk(1'b1, 16'h0100, 1'b1, 1'b0, 1'b0, msi_dest_e'(3'h6)),
          16'h05EE);
    // one below, at and one above a small programmed limit
    for (int k = 0; k < 6; k++)
      send2(mk(1'b1, 16'h00FF + 16'(k % 3), k > 2, 1'b0, 1'b0, MSI_UCAST),
            16'h0100);
    // random traffic, tx and rx independent, idle cycles mixed in
    repeat (2000) begin
      m1 = 16'($urandom_range(1600, 60));
      m2 = 16'($urandom_range(1600, 60));
      send(rnd(m1), rnd(m2), m1, m2);
    end
    repeat (3) send2('0, 16'h05EE);
    @(negedge sys_clk);
    tests_run += 2;
    if (tx_frames !== exp_tx_n) begin
      fails++;
      $display("wrong value tx_frames expected %h seen %h",
               exp_tx_n, tx_frames);
    end
    if (rx_frames !== exp_rx_n) begin
      fails++;
      $display("wrong value rx_frames expected %h seen %h",
               exp_rx_n, rx_frames);
    end
    results();
  end

  // the run needs about 2200 cycles; ten times that means a hang
  initial begin
    #110000;
    fails++;
    results();
  end

endmodule : mac_statistics_increment_pulses_bench
